// >>> pcrc_pkg.sv
// Constants and types for the program memory checksum block
package pcrc_pkg;
	// Checksum byte register addresses on the debug link
	localparam logic [7:0]  ADDR_CHECKSUM_BYTE0 = 8'hA9;
	localparam logic [7:0]  ADDR_CHECKSUM_BYTE1 = 8'hAA;
	localparam logic [7:0]  ADDR_CHECKSUM_BYTE2 = 8'hAB;
	localparam logic [7:0]  ADDR_CHECKSUM_BYTE3 = 8'hAC;
	localparam logic [7:0]  CHECKSUM_RESET      = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
	// Scan ranges
	localparam logic [15:0] FULL_START_ADDR     = 16'h0000;
	localparam logic [15:0] FULL_LAST_COUNT     = 16'h1FFF;
	localparam logic [15:0] BLOCK_LAST_COUNT    = 16'h00FF;
	localparam logic [7:0]  BLOCK_LOW_ADDR      = 8'h00;
	// Polynomials, plain defaults
	localparam logic [15:0] CRC16_POLY          = 16'h1021;
	localparam logic [31:0] CRC32_POLY          = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT            = 32'h0000_0000;
	// Link reset: clock pin held low at least this long
	localparam int          CLK_HZ              = 20_000_000;
	localparam int          LINK_RESET_NS       = 20_000;
	localparam logic [8:0]  LINK_RESET_CYC      =
		9'((LINK_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
	// Link instruction codes
	localparam logic [1:0]  INS_DATA_RD         = 2'h0;
	localparam logic [1:0]  INS_DATA_WR         = 2'h1;
	localparam logic [1:0]  INS_ADDR_RD         = 2'h2;
	localparam logic [1:0]  INS_ADDR_WR         = 2'h3;

	typedef enum logic [2:0] {
		PCRC_L_IDLE = 3'b000,
		PCRC_L_INS  = 3'b001,
		PCRC_L_ADDR = 3'b010,
		PCRC_L_LEN  = 3'b011,
		PCRC_L_DIN  = 3'b100,
		PCRC_L_WAIT = 3'b101,
		PCRC_L_DOUT = 3'b110,
		PCRC_L_STOP = 3'b111
	} pcrc_link_e;

	typedef enum logic [1:0] {
		PCRC_E_IDLE = 2'b00,
		PCRC_E_READ = 2'b01,
		PCRC_E_ACC  = 2'b10
	} pcrc_eng_e;
endpackage

// >>> pcrc_crc_if.sv
// Signals between the link controller and the checksum engine
`timescale 1ns/1ps
interface pcrc_crc_if;
	logic        start_blk;
	logic        start_full;
	logic [7:0]  blk_hi;
	logic        busy;
	logic        done;
	logic        is_full;
	logic [31:0] result;
	logic [15:0] pm_addr;
	logic [7:0]  pm_data;

	modport engine (input start_blk, start_full, blk_hi, pm_data,
		output busy, done, is_full, result, pm_addr);
	modport ctrl (output start_blk, start_full, blk_hi, pm_data,
		input busy, done, is_full, result, pm_addr);
endinterface

// >>> pcrc_crc_engine.sv
// Checksum engine scanning program memory one byte per two cycles
`timescale 1ns/1ps
module pcrc_crc_engine (
	input  wire logic     i_core_clk,   // Core clock
	input  wire logic     i_srst,       // Sync reset, high
	pcrc_crc_if.engine    bus           // Start, memory and result
);
	import pcrc_pkg::*;

	pcrc_eng_e   state;
	logic [15:0] remain;
	logic [31:0] crc;
	logic        full;
	logic [31:0] next_crc;

	// Eight serial steps per byte, msb first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
		input logic wide);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = (wide ? r[31] : r[15]) ^ d[i];
			r  = {r[30:0], 1'b0};
			if (fb) begin
				r = r ^ (wide ? CRC32_POLY : {16'h0000, CRC16_POLY});
			end
		end
		return wide ? r : {16'h0000, r[15:0]};
	endfunction

	assign next_crc    = crc_byte(crc, bus.pm_data, full);
	assign bus.busy    = (state != PCRC_E_IDLE);
	assign bus.is_full = full;

	// Address stands one cycle, data is folded in the next
	always_ff @(posedge i_core_clk) begin
		bus.done <= 1'b0;
		if (i_srst) begin
			state       <= PCRC_E_IDLE;
			remain      <= 16'h0000;
			crc         <= CRC_INIT;
			full        <= 1'b0;
			bus.pm_addr <= FULL_START_ADDR;
			bus.result  <= CRC_INIT;
		end else begin
			case (state)
				PCRC_E_IDLE: begin
					if (bus.start_full) begin
						full        <= 1'b1;
						bus.pm_addr <= FULL_START_ADDR;
						remain      <= FULL_LAST_COUNT;
						crc         <= CRC_INIT;
						state       <= PCRC_E_READ;
					end else if (bus.start_blk) begin
						full        <= 1'b0;
						bus.pm_addr <= {bus.blk_hi, BLOCK_LOW_ADDR};
						remain      <= BLOCK_LAST_COUNT;
						crc         <= CRC_INIT;
						state       <= PCRC_E_READ;
					end
				end
				PCRC_E_READ: begin
					state <= PCRC_E_ACC;
				end
				PCRC_E_ACC: begin
					crc <= next_crc;
					if (remain == 16'h0000) begin
						bus.result <= next_crc;
						bus.done   <= 1'b1;
						state      <= PCRC_E_IDLE;
					end else begin
						bus.pm_addr <= bus.pm_addr + 16'h0001;
						remain      <= remain - 16'h0001;
						state       <= PCRC_E_READ;
					end
				end
				default: begin
					state <= PCRC_E_IDLE;
				end
			endcase
		end
	end

	a_full_from_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
		(state == PCRC_E_IDLE) && bus.start_full |=> bus.pm_addr == 16'h0000 && full)
		else $error("full scan did not start at address zero");
	a_block_base: assert property (@(posedge i_core_clk) disable iff (i_srst)
		(state == PCRC_E_IDLE) && !bus.start_full && bus.start_blk
		|=> bus.pm_addr == {$past(bus.blk_hi), 8'h00} && remain == 16'h00FF)
		else $error("block scan base or length wrong");
	a_addr_step: assert property (@(posedge i_core_clk) disable iff (i_srst)
		(state == PCRC_E_ACC) && remain != 16'h0000
		|=> bus.pm_addr == $past(bus.pm_addr) + 16'h0001)
		else $error("scan address did not advance by one");
	c_full_done: cover property (@(posedge i_core_clk) disable iff (i_srst)
		bus.done && full);
endmodule

// >>> pcrc_debug_link.sv
// Debug link slave with checksum byte registers and halt control
`timescale 1ns/1ps
module pcrc_debug_link (
	input  wire logic        i_core_clk,        // Core clock, 20 MHz
	input  wire logic        i_srst,            // Sync reset, high
	input  wire logic        i_debug_clock_pin, // Link clock, shares reset pin
	input  wire logic        i_debug_data_pin,  // Link data pin level
	output logic             o_debug_data_pin,  // Link data driven value
	output logic             o_debug_data_oe,   // High while we drive data
	output logic [15:0]      o_pm_addr,         // Program memory byte address
	input  wire logic [7:0]  i_pm_data,         // Program memory data, next cycle
	output logic             o_periph_stall,    // Core and peripherals stalled
	output logic             o_user_reset,      // Pin reset to user logic
	output logic             o_crc_busy         // Checksum scan running
);
	import pcrc_pkg::*;

	pcrc_crc_if crc_bus ();

	logic [2:0]  ck_sync;
	logic [1:0]  d_sync;
	logic [8:0]  low_cnt;
	logic        halted;
	logic        reset_tail;
	pcrc_link_e  state;
	logic [2:0]  bit_cnt;
	logic [1:0]  ins;
	logic [7:0]  shreg;
	logic [7:0]  addr_reg;
	logic [7:0]  out_reg;
	logic        wr_stb;
	logic [7:0]  wr_data;
	logic [7:0]  regs [0:3];

	// Edge and level decode of the synchronised pins
	wire         ck_rise    = ck_sync[1] & ~ck_sync[2];
	wire         ck_low     = ~ck_sync[1];
	wire         din        = d_sync[1];
	wire         link_reset = ck_low && (low_cnt == LINK_RESET_CYC - 9'd1);
	// The rise that ends a link reset is not a frame start
	wire         step       = ck_rise & halted & ~reset_tail;
	wire [1:0]   next_ins   = {din, ins[1]};
	wire [7:0]   next_shreg = {din, shreg[7:1]};
	wire         last_bit   = (bit_cnt == 3'd7);

	// Register address decode
	wire         sel0 = (addr_reg == ADDR_CHECKSUM_BYTE0);
	wire         sel1 = (addr_reg == ADDR_CHECKSUM_BYTE1);
	wire         sel2 = (addr_reg == ADDR_CHECKSUM_BYTE2);
	wire         sel3 = (addr_reg == ADDR_CHECKSUM_BYTE3);
	wire [7:0]   rd_data = sel0 ? regs[0] : sel1 ? regs[1] : sel2 ? regs[2] :
		sel3 ? regs[3] : UNMAPPED_READ;

	// Starts are dropped while a scan runs; the adapter must poll busy
	assign crc_bus.start_blk  = wr_stb & sel0 & ~crc_bus.busy;
	assign crc_bus.start_full = wr_stb & sel1 & ~crc_bus.busy;
	assign crc_bus.blk_hi     = wr_data;
	assign crc_bus.pm_data    = i_pm_data;
	assign o_pm_addr          = crc_bus.pm_addr;
	assign o_crc_busy         = crc_bus.busy;
	assign o_periph_stall     = halted;

	pcrc_crc_engine u_engine (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.bus        (crc_bus.engine)
	);

	// Two flops on the data pin, three on the clock pin for edge detect; stage 0 feeds only stage 1
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ck_sync <= 3'b111;
			d_sync  <= 2'b11;
		end else begin
			ck_sync <= {ck_sync[1:0], i_debug_clock_pin};
			d_sync  <= {d_sync[0], i_debug_data_pin};
		end
	end

	// Long low on the clock pin halts the device and resets the link
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			low_cnt      <= 9'd0;
			halted       <= 1'b0;
			reset_tail   <= 1'b0;
			o_user_reset <= 1'b0;
		end else begin
			reset_tail   <= link_reset;
			low_cnt      <= !ck_low ? 9'd0 : (link_reset ? low_cnt : low_cnt + 9'd1);
			halted       <= halted | link_reset;
			o_user_reset <= ck_low & ~halted & ~link_reset;
		end
	end

	// Frame sequencer, one step per link clock rise
	always_ff @(posedge i_core_clk) begin
		wr_stb <= 1'b0;
		if (i_srst || link_reset) begin
			state    <= PCRC_L_IDLE;
			bit_cnt  <= 3'd0;
			ins      <= 2'h0;
			shreg    <= 8'h00;
			addr_reg <= 8'h00;
			out_reg  <= 8'h00;
			wr_data  <= 8'h00;
		end else if (step) begin
			bit_cnt <= bit_cnt + 3'd1;
			case (state)
				PCRC_L_IDLE: begin
					state   <= PCRC_L_INS;
					bit_cnt <= 3'd0;
				end
				PCRC_L_INS: begin
					ins <= next_ins;
					if (bit_cnt == 3'd1) begin
						bit_cnt <= 3'd0;
						if (next_ins == INS_ADDR_WR) begin
							state <= PCRC_L_ADDR;
						end else if (next_ins == INS_ADDR_RD) begin
							out_reg <= {7'h00, crc_bus.busy};
							state   <= PCRC_L_DOUT;
						end else begin
							state <= PCRC_L_LEN;
						end
					end
				end
				PCRC_L_ADDR: begin
					shreg <= next_shreg;
					if (last_bit) begin
						addr_reg <= next_shreg;
						state    <= PCRC_L_STOP;
					end
				end
				PCRC_L_LEN: begin
					if (bit_cnt == 3'd1) begin
						bit_cnt <= 3'd0;
						state   <= (ins == INS_DATA_WR) ? PCRC_L_DIN : PCRC_L_WAIT;
					end
				end
				PCRC_L_DIN: begin
					shreg <= next_shreg;
					if (last_bit) begin
						wr_data <= next_shreg;
						wr_stb  <= 1'b1;
						state   <= PCRC_L_WAIT;
					end
				end
				PCRC_L_WAIT: begin
					bit_cnt <= 3'd0;
					if (ins == INS_DATA_RD) begin
						out_reg <= rd_data;
						state   <= PCRC_L_DOUT;
					end else begin
						state <= PCRC_L_STOP;
					end
				end
				PCRC_L_DOUT: begin
					out_reg <= {1'b0, out_reg[7:1]};
					if (last_bit) begin
						state <= PCRC_L_STOP;
					end
				end
				default: begin
					state <= PCRC_L_IDLE;
				end
			endcase
		end
	end

	// Data pin driver, wait field always reports ready
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_debug_data_oe  <= 1'b0;
			o_debug_data_pin <= 1'b0;
		end else begin
			o_debug_data_oe  <= halted &&
				(state == PCRC_L_WAIT || state == PCRC_L_DOUT);
			o_debug_data_pin <= (state == PCRC_L_WAIT) ? 1'b1 : out_reg[0];
		end
	end

	// Results land on completion and beat a same-cycle link write
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			for (int i = 0; i < 4; i++) begin
				regs[i] <= CHECKSUM_RESET;
			end
		end else if (crc_bus.done && crc_bus.is_full) begin
			regs[3] <= crc_bus.result[31:24];
			regs[2] <= crc_bus.result[23:16];
			regs[1] <= crc_bus.result[15:8];
			regs[0] <= crc_bus.result[7:0];
		end else if (crc_bus.done) begin
			regs[1] <= crc_bus.result[15:8];
			regs[0] <= crc_bus.result[7:0];
		end else if (wr_stb) begin
			if (sel0) begin
				regs[0] <= wr_data;
			end else if (sel1) begin
				regs[1] <= wr_data;
			end else if (sel2) begin
				regs[2] <= wr_data;
			end else if (sel3) begin
				regs[3] <= wr_data;
			end
		end
	end

	a_halt_on_reset: assert property (@(posedge i_core_clk) disable iff (i_srst)
		link_reset |=> halted && o_periph_stall)
		else $error("link reset did not halt the device");
	a_no_reset_halted: assert property (@(posedge i_core_clk) disable iff (i_srst)
		halted |=> !o_user_reset)
		else $error("pin reset reached user logic while halted");
	a_drive_only_halted: assert property (@(posedge i_core_clk) disable iff (i_srst)
		o_debug_data_oe |-> halted)
		else $error("data pin driven while not halted");
	a_full_start: assert property (@(posedge i_core_clk) disable iff (i_srst)
		wr_stb && sel1 && !crc_bus.busy |=> crc_bus.busy ##1 crc_bus.pm_addr == 16'h0000)
		else $error("byte1 write did not start full scan");
	a_regs_reset: assert property (@(posedge i_core_clk)
		$fell(i_srst) |-> regs[0] == 8'h00 && regs[1] == 8'h00 && regs[2] == 8'h00
		&& regs[3] == 8'h00)
		else $error("checksum registers not cleared by reset");
	a_reg_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
		wr_stb && sel2 && !crc_bus.done |=> regs[2] == $past(wr_data))
		else $error("byte2 write not stored");
	a_full_result: assert property (@(posedge i_core_clk) disable iff (i_srst)
		crc_bus.done && crc_bus.is_full
		|=> {regs[3], regs[2], regs[1], regs[0]} == $past(crc_bus.result))
		else $error("full result byte order wrong");
	a_block_result: assert property (@(posedge i_core_clk) disable iff (i_srst)
		crc_bus.done && !crc_bus.is_full
		|=> {regs[1], regs[0]} == $past(crc_bus.result[15:0]) && $stable(regs[3]))
		else $error("block result placement wrong");
	a_block_start: assert property (@(posedge i_core_clk) disable iff (i_srst)
		wr_stb && sel0 && !crc_bus.busy |=> crc_bus.busy && !crc_bus.is_full)
		else $error("byte0 write did not start block scan");
	c_link_read: cover property (@(posedge i_core_clk) disable iff (i_srst)
		step && state == PCRC_L_WAIT && ins == INS_DATA_RD);
	c_block_done: cover property (@(posedge i_core_clk) disable iff (i_srst)
		crc_bus.done && !crc_bus.is_full);
	c_halt: cover property (@(posedge i_core_clk) disable iff (i_srst) $rose(halted));
endmodule

// >>> pcrc_adapter.sv
// Debug adapter model for the two-wire debug link
`timescale 1ns/1ps
module pcrc_adapter (
	output logic      o_ck, // Link clock on shared reset pin
	output logic      o_d,  // Host data value
	input  wire logic i_w   // Data wire level
);
	initial begin
		o_ck = 1'b1;
		o_d  = 1'b0;
	end
	// Long low halts the target; the pin is then released high for 400 ns
	task automatic hold_low(input int ns);
		o_ck = 1'b0;
		#(ns);
		o_ck = 1'b1;
		#400;
	endtask
	// One pulse; data moves mid-low only, steady across the rise
	task automatic pulse(input logic drv, input logic v, output logic got);
		o_ck = 1'b0;
		#100;
		o_d = drv ? v : ~o_d;
		#100;
		got = i_w;
		o_ck = 1'b1;
		#200;
	endtask
	task automatic send(input logic [7:0] v, input int n);
		logic g;
		for (int i = 0; i < n; i++) pulse(1'b1, v[i], g);
	endtask
	task automatic recv(output logic [7:0] v, input int n);
		v = 8'h00;
		for (int i = 0; i < n; i++) pulse(1'b0, 1'b0, v[i]);
	endtask
	// Frames: start, instruction, fields LSB first, stop
	task automatic set_addr(input logic [7:0] a);
		send(8'h06, 3);
		send(a, 8);
		send(8'h00, 1);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] g;
		set_addr(a);
		send(8'h02, 5);
		send(v, 8);
		recv(g, 1);
		send(8'h00, 1);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		logic [7:0] g;
		set_addr(a);
		send(8'h00, 5);
		recv(g, 1);
		recv(v, 8);
		send(8'h00, 1);
	endtask
	// Results are only read once busy has dropped, bounded poll
	task automatic wait_idle(output logic ok);
		logic [7:0] s;
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			send(8'h04, 3);
			recv(s, 8);
			send(8'h00, 1);
			ok = (s[0] === 1'b0);
		end
	endtask
endmodule

// >>> pcrc_debug_link_tb.sv
// Self-checking bench for the debug link checksum block
`timescale 1ns/1ps
module pcrc_debug_link_tb;
	import pcrc_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        h_ck;
	logic        h_d;
	logic        o_d;
	logic        o_oe;
	logic [15:0] pm_addr;
	logic [7:0]  pm_data = 8'h00;
	logic        stall;
	logic        urst;
	logic        busy;
	logic        busy_q = 1'b0;
	logic [15:0] first_addr = 16'h0000;
	logic [31:0] seed = 32'hA3D92561;
	logic [7:0]  mem [0:8191];
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc = 0;
	wire         dwire = o_oe ? o_d : h_d; // Device wins while it drives

	pcrc_debug_link dut (
		.i_core_clk        (clk),
		.i_srst            (srst),
		.i_debug_clock_pin (h_ck),
		.i_debug_data_pin  (dwire),
		.o_debug_data_pin  (o_d),
		.o_debug_data_oe   (o_oe),
		.o_pm_addr         (pm_addr),
		.i_pm_data         (pm_data),
		.o_periph_stall    (stall),
		.o_user_reset      (urst),
		.o_crc_busy        (busy)
	);
	pcrc_adapter host (
		.o_ck (h_ck),
		.o_d  (h_d),
		.i_w  (dwire)
	);

	always #25 clk = ~clk;
	// Memory answers one cycle after the address
	always @(posedge clk) pm_data <= #1 mem[pm_addr[12:0]];
	// First address of each scan, and the hang limit
	always @(posedge clk) begin
		busy_q <= busy;
		if (busy && !busy_q) first_addr <= pm_addr;
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			test_done();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// MSB-first reference checksum over memory
	function automatic logic [31:0] crc_exp(input logic [15:0] base, input int n, input int w);
		logic [31:0] c;
		logic [31:0] p;
		c = CRC_INIT;
		p = (w == 32) ? CRC32_POLY : {16'h0000, CRC16_POLY};
		for (int a = 0; a < n; a++) begin
			c = c ^ ({24'h000000, mem[13'(base + a)]} << (w - 8));
			for (int b = 0; b < 8; b++) c = c[w - 1] ? ((c << 1) ^ p) : (c << 1);
			if (w == 16) c = c & 32'h0000FFFF;
		end
		return c;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd_reg(a, v);
		check(32'(v), 32'(exp));
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		logic [7:0]  hi;
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic        ok;
		logic [31:0] e;
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		// Before halt a low pin is a plain reset
		fork
			host.hold_low(1000);
			begin
				#700;
				check(32'(urst), 32'h1);
				check(32'(stall), 32'h0);
			end
		join
		host.hold_low(25000);
		check(32'(stall), 32'h1);
		for (int a = 8'hA9; a <= 8'hAC; a++) chk_reg(8'(a), CHECKSUM_RESET);
		chk_reg(8'h55, UNMAPPED_READ);
		b2 = 8'(rnd());
		b3 = 8'(rnd());
		host.wr_reg(ADDR_CHECKSUM_BYTE2, b2);
		host.wr_reg(ADDR_CHECKSUM_BYTE3, b3);
		// Halted: link pulses must not reach user reset
		fork
			chk_reg(ADDR_CHECKSUM_BYTE2, b2);
			begin
				@(negedge h_ck);
				#100;
				check(32'(urst), 32'h0);
			end
		join
		chk_reg(ADDR_CHECKSUM_BYTE3, b3);
		// Block then full scan, top block first as a corner
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 8192; i++) mem[i] = 8'(rnd());
			hi = (r == 0) ? 8'h1F : 8'(rnd() % 32);
			host.wr_reg(ADDR_CHECKSUM_BYTE0, hi);
			host.wait_idle(ok);
			check(32'(ok), 32'h1);
			check(32'(first_addr), 32'({hi, BLOCK_LOW_ADDR}));
			e = crc_exp({hi, BLOCK_LOW_ADDR}, 256, 16);
			chk_reg(ADDR_CHECKSUM_BYTE0, e[7:0]);
			chk_reg(ADDR_CHECKSUM_BYTE1, e[15:8]);
			chk_reg(ADDR_CHECKSUM_BYTE2, b2);
			chk_reg(ADDR_CHECKSUM_BYTE3, b3);
			host.wr_reg(ADDR_CHECKSUM_BYTE1, 8'(rnd()));
			host.wait_idle(ok);
			check(32'(ok), 32'h1);
			check(32'(first_addr), 32'(FULL_START_ADDR));
			e = crc_exp(FULL_START_ADDR, 8192, 32);
			chk_reg(ADDR_CHECKSUM_BYTE0, e[7:0]);
			chk_reg(ADDR_CHECKSUM_BYTE1, e[15:8]);
			chk_reg(ADDR_CHECKSUM_BYTE2, e[23:16]);
			chk_reg(ADDR_CHECKSUM_BYTE3, e[31:24]);
			b2 = e[23:16];
			b3 = e[31:24];
		end
		test_done();
	end
endmodule
